// >>> rtl/dtar_regs.svh
// Register indices, field positions, reset values and timing counts
// for the die temperature ADC readout. Included by every file that uses
// the macros; the guard keeps a second inclusion harmless.
`ifndef DTAR_REGS_SVH
`define DTAR_REGS_SVH

// Register indices; byte address is four times the index
`define DTAR_IDX_TRIG 6'h1b
`define DTAR_IDX_DONE 6'h1c
`define DTAR_IDX_SAMPLE 6'h1d
`define DTAR_IDX_IRQ_STAT 6'h1e
`define DTAR_IDX_IRQ_MASK 6'h1f

// Field positions
`define DTAR_BIT_TRIGGER 0
`define DTAR_BIT_RATE_SEL 1
`define DTAR_BIT_DONE 0

// Reset values
`define DTAR_RST_RATE_SEL 1'h0
`define DTAR_RST_DONE 1'h1
`define DTAR_RST_SAMPLE 8'hbd
`define DTAR_RST_MASK 1'h0

// Timing: system clock and converter clock periods in ns
`define DTAR_SYS_PERIOD_NS 40
`define DTAR_FAST_PERIOD_NS 500
`define DTAR_SLOW_PERIOD_NS 4000
`define DTAR_FAST_DIV (`DTAR_FAST_PERIOD_NS / `DTAR_SYS_PERIOD_NS)
`define DTAR_SLOW_DIV (`DTAR_SLOW_PERIOD_NS / `DTAR_SYS_PERIOD_NS)
`define DTAR_CONV_TICKS 17

`endif

// >>> rtl/dtar_pkg.sv
// Types shared by the die temperature ADC readout.
// Assumes dtar_regs.svh sits on the include path.
`include "dtar_regs.svh"

package dtar_pkg;

    // Conversion sequencer states
    typedef enum logic [0:0] {
        DTAR_IDLE = 1'b0,
        DTAR_CONV = 1'b1
    } dtar_state_type;

    typedef logic [6:0] dtar_div_type;
    typedef logic [4:0] dtar_tick_cnt_type;

endpackage

// >>> rtl/dtar_clk_div.sv
// Converter clock enable: one-cycle pulse at the selected rate.
// Assumes a single system clock; restart realigns the first tick.
`include "dtar_regs.svh"

module dtar_clk_div
    import dtar_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_rate_sel,
    input wire logic i_restart,
    // Enable out
    output logic o_tick
);

    dtar_div_type count;
    dtar_div_type next_count;
    logic next_tick;
    dtar_div_type last;

    // Terminal count for the chosen rate
    always_comb begin
        last = i_rate_sel ? dtar_div_type'(`DTAR_SLOW_DIV - 1)
                          : dtar_div_type'(`DTAR_FAST_DIV - 1);
        next_count = count + 7'h01;
        next_tick = 1'b0;
        if (i_restart) begin
            next_count = 7'h00;
        end else if (count >= last) begin
            // >= covers a rate change while the count is past the new end
            next_count = 7'h00;
            next_tick = 1'b1;
        end
    end

    // Register state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count <= 7'h00;
            o_tick <= 1'b0;
        end else begin
            count <= next_count;
            o_tick <= next_tick;
        end
    end

endmodule

// >>> rtl/dtar_top.sv
// APB slave and conversion sequencer for the housekeeping ADC that
// reads die temperature. Assumes i_conv_sample is the converter code
// taken from the sensor mux, changing slowly and asynchronously.
`include "dtar_regs.svh"

module dtar_top
    import dtar_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Converter code from the temperature sensor mux
    input wire logic [7:0] i_conv_sample,
    // Interrupt
    output logic o_irq
);

    dtar_state_type state;
    dtar_state_type next_state;
    dtar_tick_cnt_type ticks;
    dtar_tick_cnt_type next_ticks;
    logic conv_clock_rate_sel;
    logic next_rate_sel;
    logic done;
    logic next_done;
    logic [7:0] temp_adc_sample_value;
    logic [7:0] next_sample;
    logic irq_stat;
    logic next_irq_stat;
    logic irq_mask;
    logic next_irq_mask;
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_irq;
    logic [7:0] sample_meta;
    logic [7:0] sample_sync;
    logic conv_tick;
    logic setup;
    logic xfer;
    logic wr;
    logic rd;
    logic hit_trig;
    logic hit_done;
    logic hit_sample;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic conv_trigger;
    logic conv_start;
    logic finish;

    // Two-flop synchroniser on the analog converter code; the code is
    // treated as quasi-static, a limitation accepted for a slow sensor
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sample_meta <= 8'h00;
            sample_sync <= 8'h00;
        end else begin
            sample_meta <= i_conv_sample;
            sample_sync <= sample_meta;
        end
    end

    // Address decode on word index; low address bits must be zero
    always_comb begin
        hit_trig = 1'b0;
        hit_done = 1'b0;
        hit_sample = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        if (i_paddr[1:0] != 2'h0) begin
            hit_trig = 1'b0;
        end else if (i_paddr[7:2] == `DTAR_IDX_TRIG) begin
            hit_trig = 1'b1;
        end else if (i_paddr[7:2] == `DTAR_IDX_DONE) begin
            hit_done = 1'b1;
        end else if (i_paddr[7:2] == `DTAR_IDX_SAMPLE) begin
            hit_sample = 1'b1;
        end else if (i_paddr[7:2] == `DTAR_IDX_IRQ_STAT) begin
            hit_stat = 1'b1;
        end else if (i_paddr[7:2] == `DTAR_IDX_IRQ_MASK) begin
            hit_mask = 1'b1;
        end
        mapped = hit_trig | hit_done | hit_sample | hit_stat | hit_mask;
    end

    // Bus phases; a transfer completes on the edge where pready is high
    assign setup = i_psel & ~i_penable;
    assign xfer = i_psel & i_penable & o_pready;
    assign wr = xfer & i_pwrite;
    assign rd = xfer & ~i_pwrite;
    assign conv_trigger = wr & hit_trig & i_pwdata[`DTAR_BIT_TRIGGER];
    // Only a trigger taken while idle starts a conversion
    assign conv_start = conv_trigger & (state == DTAR_IDLE);
    assign finish = (state == DTAR_CONV) && conv_tick
                    && (ticks == 5'(`DTAR_CONV_TICKS - 1));

    // APB answer: data latched in setup, ready for one access cycle
    always_comb begin
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = o_prdata;
        if (setup) begin
            next_pready = 1'b1;
            next_pslverr = ~mapped;
            next_prdata = 32'h0000_0000;
            if (hit_trig) begin
                next_prdata[`DTAR_BIT_RATE_SEL] = conv_clock_rate_sel;
                // Trigger reads back high while the conversion runs
                next_prdata[`DTAR_BIT_TRIGGER] = (state == DTAR_CONV);
            end else if (hit_done) begin
                next_prdata[`DTAR_BIT_DONE] = done;
            end else if (hit_sample) begin
                next_prdata[7:0] = temp_adc_sample_value;
            end else if (hit_stat) begin
                next_prdata[`DTAR_BIT_DONE] = irq_stat;
            end else if (hit_mask) begin
                next_prdata[`DTAR_BIT_DONE] = irq_mask;
            end
        end
    end

    // Control registers and the conversion sequencer
    always_comb begin
        next_state = state;
        next_ticks = ticks;
        next_done = done;
        next_sample = temp_adc_sample_value;
        next_rate_sel = conv_clock_rate_sel;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (wr && hit_trig) begin
            next_rate_sel = i_pwdata[`DTAR_BIT_RATE_SEL];
        end
        if (wr && hit_mask) begin
            next_irq_mask = i_pwdata[`DTAR_BIT_DONE];
        end
        // Read clears only a bit that the read returned, so an event on
        // the setup edge is kept; a done event at the clear still wins
        if (rd && hit_stat && o_prdata[`DTAR_BIT_DONE]) begin
            next_irq_stat = 1'b0;
        end
        case (state)
            DTAR_IDLE: begin
                // A trigger during a conversion is ignored, not queued
                if (conv_trigger) begin
                    next_state = DTAR_CONV;
                    next_ticks = 5'h00;
                    next_done = 1'b0;
                end
            end
            DTAR_CONV: begin
                if (finish) begin
                    next_state = DTAR_IDLE;
                    next_sample = sample_sync;
                    next_done = 1'b1;
                    next_irq_stat = 1'b1;
                end else if (conv_tick) begin
                    next_ticks = ticks + 5'h01;
                end
            end
            default: begin
                next_state = DTAR_IDLE;
            end
        endcase
        next_irq = next_irq_stat & next_irq_mask;
    end

    // Converter clock enable, realigned when a conversion starts; a
    // trigger while busy must not stretch the running conversion
    dtar_clk_div u_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_rate_sel(conv_clock_rate_sel),
        .i_restart(conv_start),
        .o_tick(conv_tick)
    );

    // Register all state but the synchroniser
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= DTAR_IDLE;
            ticks <= 5'h00;
            done <= `DTAR_RST_DONE;
            temp_adc_sample_value <= `DTAR_RST_SAMPLE;
            conv_clock_rate_sel <= `DTAR_RST_RATE_SEL;
            irq_mask <= `DTAR_RST_MASK;
            irq_stat <= 1'b0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_irq <= 1'b0;
        end else begin
            state <= next_state;
            ticks <= next_ticks;
            done <= next_done;
            temp_adc_sample_value <= next_sample;
            conv_clock_rate_sel <= next_rate_sel;
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
            o_pready <= next_pready;
            o_pslverr <= next_pslverr;
            o_prdata <= next_prdata;
            o_irq <= next_irq;
        end
    end

    // Checks
    chk_fast_tick: assert property (@(posedge i_clk) disable iff (i_rst)
        (conv_tick && !conv_clock_rate_sel && $stable(conv_clock_rate_sel))
        |=> !conv_tick [*8])
        else $error("fast converter tick came too soon");

    chk_done_clear: assert property (@(posedge i_clk) disable iff (i_rst)
        (conv_trigger && state == DTAR_IDLE) |=> !done ##1 !done)
        else $error("done flag not cleared by trigger");

    chk_done_busy: assert property (@(posedge i_clk) disable iff (i_rst)
        done == (state == DTAR_IDLE))
        else $error("done flag disagrees with sequencer");

    chk_conv_length: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(done) |-> $past(ticks) == 5'(`DTAR_CONV_TICKS - 1))
        else $error("conversion ended after wrong tick count");

    chk_result_load: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(done) |-> temp_adc_sample_value == $past(sample_sync))
        else $error("result not loaded from synchronised sample");

    chk_sensor_sync: assert property (@(posedge i_clk) disable iff (i_rst)
        sample_sync == $past(sample_meta))
        else $error("sensor code not passed through synchroniser");

    chk_result_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !$rose(done) |-> $stable(temp_adc_sample_value))
        else $error("result changed outside conversion end");

    chk_rate_write: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr && hit_trig) |=>
        conv_clock_rate_sel == $past(i_pwdata[`DTAR_BIT_RATE_SEL]))
        else $error("rate select write not stored");

    chk_irq_set: assert property (@(posedge i_clk) disable iff (i_rst)
        finish |=> irq_stat)
        else $error("conversion end did not set irq status");

endmodule

// >>> dv/tb.sv
// Self-checking bench for the die temperature ADC readout.
// Assumes dtar_regs.svh is on the include path; drives APB itself.
`include "dtar_regs.svh"

module tb;
    import dtar_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [7:0] i_conv_sample = 8'h00;
    logic o_pready;
    logic [31:0] o_prdata;
    logic o_pslverr;
    logic o_irq;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int seed = 46302;

    dtar_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
        .o_pslverr(o_pslverr), .i_conv_sample(i_conv_sample),
        .o_irq(o_irq));

    // Clock: 40 ns period
    initial begin
        forever #20 i_clk = ~i_clk;
    end

    // Cycle count doubles as the hang limit
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            failures++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask

    // One APB transfer; entered just after a rising edge, leaves one
    // idle cycle so psel is never assigned twice in one time step
    task automatic apb(input logic wr, input logic [5:0] idx,
                       input logic [1:0] lsb, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= {idx, lsb};
        i_pwdata <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        // No local limit: only the bench timeout ends a hung wait
        while (o_pready !== 1'b1) begin
            @(posedge i_clk);
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rd_chk(input string nm, input logic [5:0] idx,
                          input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 2'b00, 32'h0, d, e);
        chk(nm, exp, d);
        chk({nm, " err"}, 32'h0, {31'h0, e});
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, 2'b00, wd, d, e);
    endtask

    // Clocks from trigger to done for a rate select value
    function automatic int exp_cycles(input logic rate);
        return `DTAR_CONV_TICKS * (rate ? `DTAR_SLOW_DIV : `DTAR_FAST_DIV);
    endfunction

    initial begin
        logic [31:0] d;
        logic e;
        logic [7:0] smp;
        int t0;
        int n;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd_chk("trig reset", `DTAR_IDX_TRIG, 32'h0);
        rd_chk("done reset", `DTAR_IDX_DONE, 32'h1);
        rd_chk("sample reset", `DTAR_IDX_SAMPLE, 32'hbd);
        rd_chk("mask reset", `DTAR_IDX_IRQ_MASK, 32'h0);
        rd_chk("stat reset", `DTAR_IDX_IRQ_STAT, 32'h0);
        // Unmapped and misaligned places answer with an error
        apb(1'b0, 6'h00, 2'b00, 32'h0, d, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        apb(1'b1, `DTAR_IDX_TRIG, 2'b01, 32'h3, d, e);
        chk("misaligned err", 32'h1, {31'h0, e});
        rd_chk("trig untouched", `DTAR_IDX_TRIG, 32'h0);
        // Each rate twice, random sample except 8'hff on the first run, irq masked in on fast runs
        for (int r = 0; r < 4; r++) begin
            smp = 8'($random(seed));
            if (r == 0)
                smp = 8'hff;
            i_conv_sample <= smp;
            wr(`DTAR_IDX_IRQ_MASK, {31'h0, ~r[1]});
            wr(`DTAR_IDX_TRIG, {30'h0, r[1], 1'b1});
            t0 = cyc;
            rd_chk("busy", `DTAR_IDX_TRIG, {30'h0, r[1], 1'b1});
            rd_chk("done low", `DTAR_IDX_DONE, 32'h0);
            // A second trigger mid-run must not restart the count
            wr(`DTAR_IDX_TRIG, {30'h0, r[1], 1'b1});
            n = 0;
            d = 32'h0;
            while (d !== 32'h1 && n < 2000) begin
                apb(1'b0, `DTAR_IDX_DONE, 2'b00, 32'h0, d, e);
                n++;
            end
            n = cyc - t0;
            chk("conv time low", 32'h1,
                {31'h0, n >= exp_cycles(r[1]) - 3});
            chk("conv time high", 32'h1,
                {31'h0, n <= exp_cycles(r[1]) + 8});
            rd_chk("sample", `DTAR_IDX_SAMPLE, {24'h0, smp});
            chk("irq level", {31'h0, ~r[1]}, {31'h0, o_irq});
            rd_chk("irq stat", `DTAR_IDX_IRQ_STAT, 32'h1);
            rd_chk("irq cleared", `DTAR_IDX_IRQ_STAT, 32'h0);
            chk("irq low", 32'h0, {31'h0, o_irq});
            rd_chk("idle", `DTAR_IDX_TRIG, {30'h0, r[1], 1'b0});
        end
        summarize();
    end
endmodule
